// File: ccvr_top.sv
// charge port voltage request decoder: line negotiation, request decoding, fault sequencing
// assumes comparator pins are asynchronous; load_ma and pwm_cycle_start come from clk_sys logic
//
// Overview of operation
// RULE1 - power-up: lines shorted, reference at 5.2V
// RULE2 - negotiated: open short, pull D- down
// RULE3 - high-voltage mode follows decoded line patterns
// RULE4 - reference never above 12V
// RULE5 - unplug turns on output discharge sink
// RULE6 - continuous mode: one step per request
// RULE7 - patterns act only after 40ms stable
// RULE8 - portable side waits before continuous pulses
// RULE9 - increment is D+ pulse to up level
// RULE10 - pattern table selects 9V, 12V, continuous, 5.2V, keep
// RULE11 - grounded D- held by our pull-down
// RULE12 - sense over 130mV: driver off, current mode
// RULE13 - inductor overcurrent cuts switch this cycle
// RULE14 - short circuit: timed hiccup restarts
// RULE15 - overvoltage shuts down, auto resume
// RULE16 - overtemperature shutdown, restart below 130C
// RULE17 - cable compensation 60mV/A above 500mA
// RULE18 - incompatible device: fixed 5.2V, no adjust
// RULE19 - steps within 3.6V to 12V
// RULE20 - D- pulse to down level decrements
// RULE21 - out of range steps are ignored
`timescale 1ns/1ps
`include "ccvr_regs.svh"
module ccvr_top #(
  parameter int FILT_CYC = `CCVR_FILT_CYC,
  parameter int NEG_CYC = `CCVR_NEG_CYC,
  parameter int DMLOW_CYC = `CCVR_DMLOW_CYC,
  parameter int SS_CYC = `CCVR_SS_CYC,
  parameter int HICCUP_CYC = `CCVR_HICCUP_CYC,
  parameter int PULSE_CYC = `CCVR_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dp_above_ref,
  input wire logic dp_above_sel,
  input wire logic dm_above_ref,
  input wire logic dm_above_sel,
  input wire logic sense_over,
  input wire logic ilim_over,
  input wire logic short_det,
  input wire logic vout_over,
  input wire logic temp_hot,
  input wire logic temp_cool,
  input wire logic vout_safe,
  input wire logic [11:0] load_ma,
  input wire logic pwm_cycle_start,
  output logic line_short_en,
  output logic dminus_pulldown_en,
  output logic [7:0] vref_code,
  output logic [7:0] comp_mv,
  output logic conv_en,
  output logic soft_start,
  output logic hs_allow,
  output logic discharge_en,
  output logic constant_current_mode,
  output logic constant_voltage_mode
);
  if (FILT_CYC < 2 || NEG_CYC < 2 || DMLOW_CYC < 2 || SS_CYC < 2 || HICCUP_CYC < 2
      || PULSE_CYC < 2) begin : g_chk
    $error("timing counts must be at least 2");
  end
  function automatic ccvr_pkg::ccvr_pat_t decode_pat(input logic [3:0] l);
    // l = {dp_ref, dp_sel, dm_ref, dm_sel}
    decode_pat = ccvr_pkg::pat_keep;
    if (!l[3]) decode_pat = ccvr_pkg::pat_none;
    else if (l[2] && l[0]) decode_pat = ccvr_pkg::pat_cont;
    else if (l[2] && l[1]) decode_pat = ccvr_pkg::pat_9v;
    else if (!l[2] && l[1] && !l[0]) decode_pat = ccvr_pkg::pat_12v;
    else if (!l[2] && !l[1]) decode_pat = ccvr_pkg::pat_5v2;
  endfunction : decode_pat
  function automatic logic [7:0] step_ref(input logic [7:0] r, input logic up);
    step_ref = r;
    if (up && r <= `CCVR_REF_CLASS_MAX - `CCVR_REF_STEP) step_ref = r + `CCVR_REF_STEP;
    if (!up && r >= `CCVR_REF_MIN + `CCVR_REF_STEP) step_ref = r - `CCVR_REF_STEP; // RULE19
  endfunction : step_ref
  function automatic logic [7:0] comp_of(input logic [11:0] ma);
    logic [19:0] p;
    p = 20'(ma) * `CCVR_COMP_MV_PER_A;
    comp_of = (ma <= `CCVR_COMP_KNEE_MA) ? 8'h00 : 8'(p / `CCVR_MA_PER_A);
  endfunction : comp_of

  // two-stage synchronisers for pins
  logic [10:0] s1_r, s2_r, s1_nxt, s2_nxt;
  logic dp_ref, dp_sel, dm_ref, dm_sel, sense_s, ilim_s, short_s, ov_s, hot_s, cool_s, safe_s;
  always_comb begin
    s1_nxt = {dp_above_ref, dp_above_sel, dm_above_ref, dm_above_sel, sense_over, ilim_over,
              short_det, vout_over, temp_hot, temp_cool, vout_safe};
    s2_nxt = s1_r;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end
  assign {dp_ref, dp_sel, dm_ref, dm_sel, sense_s, ilim_s, short_s, ov_s, hot_s, cool_s,
          safe_s} = s2_r;

  ccvr_filt_if fif();
  assign fif.raw = decode_pat({dp_ref, dp_sel, dm_ref, dm_sel}); // RULE10 RULE11
  ccvr_filter #(.FILT_CYC(FILT_CYC)) u_filter (
    .clk_sys(clk_sys),
    .srst(srst),
    .fif(fif)
  );

  // register bus
  logic ack_r, ack_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, rdata_r, rdata_nxt, status_w, vref_w;
  logic adj_en;
  assign adj_en = ctrl_r[`CCVR_CTRL_ADJ_BIT];
  always_comb begin
    ack_nxt = (avs_read || avs_write) && !ack_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    if (avs_write && ack_r && avs_address == `CCVR_OFS_CTRL) ctrl_nxt[0] = avs_writedata[0];
    if (avs_read && ack_nxt) begin
      unique case (avs_address)
        `CCVR_OFS_CTRL: rdata_nxt = ctrl_r;
        `CCVR_OFS_STATUS: rdata_nxt = status_w;
        `CCVR_OFS_VREF: rdata_nxt = vref_w;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_r <= 1'b0;
      ctrl_r <= `CCVR_CTRL_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;

  // port negotiation and voltage request decoding
  ccvr_pkg::ccvr_port_t port_r, port_nxt;
  logic [31:0] pcnt_r, pcnt_nxt;
  logic [7:0] ref_r, ref_nxt, comp_r, comp_nxt;
  logic legacy_r, legacy_nxt, dis_r, dis_nxt, short_r, short_nxt, pdn_r, pdn_nxt;
  logic inc_arm_r, inc_arm_nxt, dec_arm_r, dec_arm_nxt;
  logic [31:0] inc_cnt_r, inc_cnt_nxt, dec_cnt_r, dec_cnt_nxt;
  logic inc_ev, dec_ev, dp_mid;
  assign dp_mid = dp_ref && !dp_sel;
  assign inc_ev = inc_arm_r && dp_sel && inc_cnt_r == 32'(PULSE_CYC - 1); // RULE9
  assign dec_ev = dec_arm_r && !dm_sel && dec_cnt_r == 32'(PULSE_CYC - 1); // RULE20
  always_comb begin
    port_nxt = port_r;
    pcnt_nxt = pcnt_r + 32'h0000_0001;
    ref_nxt = ref_r;
    legacy_nxt = legacy_r;
    dis_nxt = dis_r && !safe_s; // RULE5
    inc_arm_nxt = inc_arm_r || !dp_sel; // RULE8
    dec_arm_nxt = dec_arm_r || dm_sel;
    inc_cnt_nxt = (inc_arm_r && dp_sel) ? inc_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    dec_cnt_nxt = (dec_arm_r && !dm_sel) ? dec_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    unique case (port_r)
      ccvr_pkg::port_dcp: begin
        ref_nxt = `CCVR_REF_5V2; // RULE1
        if (!dp_ref) legacy_nxt = 1'b0;
        pcnt_nxt = 32'h0000_0000;
        if (dp_mid && !legacy_r && adj_en) port_nxt = ccvr_pkg::port_negot;
      end
      ccvr_pkg::port_negot: begin
        if (!dp_mid) begin
          port_nxt = ccvr_pkg::port_dcp;
          legacy_nxt = 1'b1; // RULE18
        end else if (pcnt_r == 32'(NEG_CYC - 1)) begin
          port_nxt = ccvr_pkg::port_wait_dm;
          pcnt_nxt = 32'h0000_0000;
        end
      end
      ccvr_pkg::port_wait_dm: begin
        if (!dp_ref) begin
          port_nxt = ccvr_pkg::port_dcp;
        end else if (dm_ref) begin
          pcnt_nxt = 32'h0000_0000;
        end else if (pcnt_r == 32'(DMLOW_CYC - 1)) begin
          port_nxt = ccvr_pkg::port_hv; // RULE2
        end
      end
      ccvr_pkg::port_hv, ccvr_pkg::port_cont: begin
        if (port_r == ccvr_pkg::port_cont && (inc_ev || dec_ev)) begin
          ref_nxt = step_ref(ref_r, inc_ev); // RULE6 RULE21
          inc_arm_nxt = inc_arm_r && !inc_ev;
          dec_arm_nxt = dec_arm_r && !dec_ev;
        end
        if (fif.strobe) begin // RULE3
          unique case (fif.stable)
            ccvr_pkg::pat_5v2: begin
              ref_nxt = `CCVR_REF_5V2;
              port_nxt = ccvr_pkg::port_hv;
            end
            ccvr_pkg::pat_9v: begin
              ref_nxt = `CCVR_REF_9V;
              port_nxt = ccvr_pkg::port_hv;
            end
            ccvr_pkg::pat_12v: begin
              ref_nxt = `CCVR_REF_12V; // RULE4
              port_nxt = ccvr_pkg::port_hv;
            end
            ccvr_pkg::pat_cont: begin
              port_nxt = ccvr_pkg::port_cont;
              inc_arm_nxt = 1'b0;
              dec_arm_nxt = 1'b0;
            end
            ccvr_pkg::pat_none: begin
              port_nxt = ccvr_pkg::port_dcp;
              ref_nxt = `CCVR_REF_5V2;
              dis_nxt = 1'b1; // RULE5
            end
            ccvr_pkg::pat_keep: ref_nxt = ref_nxt;
          endcase
        end
        if (!adj_en) begin
          port_nxt = ccvr_pkg::port_dcp;
          ref_nxt = `CCVR_REF_5V2;
        end
      end
      default: port_nxt = ccvr_pkg::port_dcp;
    endcase
    short_nxt = (port_nxt == ccvr_pkg::port_dcp) || (port_nxt == ccvr_pkg::port_negot);
    pdn_nxt = !short_nxt; // RULE11
    comp_nxt = comp_of(load_ma); // RULE17
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port_r <= ccvr_pkg::port_dcp;
      pcnt_r <= 32'h0000_0000;
      ref_r <= `CCVR_REF_5V2;
      comp_r <= 8'h00;
      legacy_r <= 1'b0;
      dis_r <= 1'b0;
      short_r <= 1'b1;
      pdn_r <= 1'b0;
      inc_arm_r <= 1'b0;
      dec_arm_r <= 1'b0;
      inc_cnt_r <= 32'h0000_0000;
      dec_cnt_r <= 32'h0000_0000;
    end else begin
      port_r <= port_nxt;
      pcnt_r <= pcnt_nxt;
      ref_r <= ref_nxt;
      comp_r <= comp_nxt;
      legacy_r <= legacy_nxt;
      dis_r <= dis_nxt;
      short_r <= short_nxt;
      pdn_r <= pdn_nxt;
      inc_arm_r <= inc_arm_nxt;
      dec_arm_r <= dec_arm_nxt;
      inc_cnt_r <= inc_cnt_nxt;
      dec_cnt_r <= dec_cnt_nxt;
    end
  end

  // fault sequencing and switch gating
  ccvr_pkg::ccvr_pwr_t pwr_r, pwr_nxt;
  logic [31:0] wcnt_r, wcnt_nxt;
  logic otp_r, otp_nxt, ilim_r, ilim_nxt, hs_r, hs_nxt, cur_r, cur_nxt;
  always_comb begin
    pwr_nxt = pwr_r;
    wcnt_nxt = wcnt_r + 32'h0000_0001;
    otp_nxt = hot_s || (otp_r && !cool_s); // RULE16
    ilim_nxt = ilim_s || (ilim_r && !pwm_cycle_start); // RULE13
    unique case (pwr_r)
      ccvr_pkg::pwr_sstart: if (wcnt_r == 32'(SS_CYC - 1)) pwr_nxt = ccvr_pkg::pwr_run;
      ccvr_pkg::pwr_run: wcnt_nxt = 32'h0000_0000;
      ccvr_pkg::pwr_hiccup: if (wcnt_r == 32'(HICCUP_CYC - 1)) pwr_nxt = ccvr_pkg::pwr_sstart;
      ccvr_pkg::pwr_halt: if (!otp_r && !ov_s) pwr_nxt = ccvr_pkg::pwr_sstart; // RULE15
      default: pwr_nxt = ccvr_pkg::pwr_halt;
    endcase
    if (pwr_r != ccvr_pkg::pwr_halt && pwr_r != ccvr_pkg::pwr_hiccup && short_s) begin
      pwr_nxt = ccvr_pkg::pwr_hiccup; // RULE14
    end
    if (otp_nxt || ov_s) pwr_nxt = ccvr_pkg::pwr_halt; // RULE15 RULE16
    if (pwr_nxt != pwr_r) wcnt_nxt = 32'h0000_0000;
    cur_nxt = sense_s; // RULE12
    hs_nxt = (pwr_nxt == ccvr_pkg::pwr_run || pwr_nxt == ccvr_pkg::pwr_sstart)
             && !ilim_nxt && !sense_s; // RULE12 RULE13
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pwr_r <= ccvr_pkg::pwr_sstart;
      wcnt_r <= 32'h0000_0000;
      otp_r <= 1'b0;
      ilim_r <= 1'b0;
      hs_r <= 1'b0;
      cur_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      wcnt_r <= wcnt_nxt;
      otp_r <= otp_nxt;
      ilim_r <= ilim_nxt;
      hs_r <= hs_nxt;
      cur_r <= cur_nxt;
    end
  end

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`CCVR_ST_PORT_LSB +: 5] = port_r;
    status_w[`CCVR_ST_PWR_LSB +: 4] = pwr_r;
    status_w[`CCVR_ST_LEGACY_BIT] = legacy_r;
    status_w[`CCVR_ST_OTP_BIT] = otp_r;
    status_w[`CCVR_ST_CUR_BIT] = cur_r;
    status_w[`CCVR_ST_DIS_BIT] = dis_r;
    vref_w = {16'h0000, comp_r, ref_r};
  end
  assign line_short_en = short_r;
  assign dminus_pulldown_en = pdn_r;
  assign vref_code = ref_r;
  assign comp_mv = comp_r;
  assign conv_en = pwr_r == ccvr_pkg::pwr_run || pwr_r == ccvr_pkg::pwr_sstart;
  assign soft_start = pwr_r == ccvr_pkg::pwr_sstart;
  assign hs_allow = hs_r;
  assign discharge_en = dis_r;
  assign constant_current_mode = cur_r;
  assign constant_voltage_mode = !cur_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_dcp_short: assert property ( // RULE1
    port_r == ccvr_pkg::port_dcp |-> line_short_en && !dminus_pulldown_en)
    else $error("line short missing in charging port mode");
  a_hv_pulldown: assert property ( // RULE2
    port_r == ccvr_pkg::port_hv |-> dminus_pulldown_en && !line_short_en)
    else $error("pull-down missing in high voltage mode");
  a_ref_range: assert property (vref_code >= `CCVR_REF_MIN && vref_code <= `CCVR_REF_CLASS_MAX) // RULE4
    else $error("reference out of range");
  a_one_step: assert property (port_r == ccvr_pkg::port_cont && !fif.strobe && adj_en |=> // RULE6
    (vref_code == $past(vref_code) || vref_code == $past(vref_code) + `CCVR_REF_STEP
     || vref_code == $past(vref_code) - `CCVR_REF_STEP))
    else $error("more than one step per request");
  a_unplug_sink: assert property (fif.strobe && fif.stable == ccvr_pkg::pat_none // RULE5
    && (port_r == ccvr_pkg::port_hv || port_r == ccvr_pkg::port_cont)
    |=> discharge_en && vref_code == `CCVR_REF_5V2)
    else $error("discharge not started on unplug");
  a_sel_9v: assert property (fif.strobe && fif.stable == ccvr_pkg::pat_9v // RULE10
    && port_r == ccvr_pkg::port_hv && adj_en |=> vref_code == `CCVR_REF_9V)
    else $error("9V pattern not applied");
  a_ilim_cut: assert property ($rose(ilim_s) |=> !hs_allow) // RULE13
    else $error("switch not cut on overcurrent");
  a_sense_cut: assert property (sense_s |=> !hs_allow && constant_current_mode) // RULE12
    else $error("driver not off in current limit");
  a_halt_off: assert property (pwr_r == ccvr_pkg::pwr_halt |-> !conv_en) // RULE15
    else $error("converter runs while halted");
  a_hot_halt: assert property (hot_s |=> pwr_r == ccvr_pkg::pwr_halt) // RULE16
    else $error("no shutdown on overtemperature");
  a_short_hiccup: assert property (short_s && pwr_r == ccvr_pkg::pwr_run && !ov_s // RULE14
    && !otp_r && !hot_s |=> pwr_r == ccvr_pkg::pwr_hiccup)
    else $error("no hiccup on short");
  a_legacy_5v: assert property (legacy_r |-> vref_code == `CCVR_REF_5V2) // RULE18
    else $error("legacy device not held at 5.2V");
  c_cont_mode: cover property (port_r == ccvr_pkg::port_cont);
  c_step_up: cover property (port_r == ccvr_pkg::port_cont && inc_ev);
  c_hiccup: cover property (pwr_r == ccvr_pkg::pwr_hiccup ##1 pwr_r == ccvr_pkg::pwr_sstart);
  c_unplug: cover property ($rose(discharge_en));
endmodule : ccvr_top

// File: ccvr_regs.svh
// constants of the charge port voltage request decoder: offsets, reset values, codes, timing
// assumes a 40 MHz system clock; reference codes are in units of 100 mV of bus voltage
`ifndef CCVR_REGS_SVH
`define CCVR_REGS_SVH
`define CCVR_CLK_HZ 40000000
`define CCVR_OFS_CTRL 4'h0
`define CCVR_OFS_STATUS 4'h4
`define CCVR_OFS_VREF 4'h8
`define CCVR_CTRL_RST 32'h0000_0001
`define CCVR_CTRL_ADJ_BIT 0
`define CCVR_ST_PORT_LSB 0
`define CCVR_ST_PWR_LSB 5
`define CCVR_ST_LEGACY_BIT 9
`define CCVR_ST_OTP_BIT 10
`define CCVR_ST_CUR_BIT 11
`define CCVR_ST_DIS_BIT 12
`define CCVR_VREF_COMP_LSB 8
`define CCVR_REF_5V2 8'h34
`define CCVR_REF_9V 8'h5a
`define CCVR_REF_12V 8'h78
`define CCVR_REF_MIN 8'h24
`define CCVR_REF_TOP 8'h79
`define CCVR_REF_CLASS_MAX 8'h78
`define CCVR_REF_STEP 8'h02
`define CCVR_COMP_KNEE_MA 12'h1f4
`define CCVR_COMP_MV_PER_A 20'h0_003c
`define CCVR_MA_PER_A 20'h0_03e8
`define CCVR_FILT_MS 40
`define CCVR_NEG_MS 1000
`define CCVR_DMLOW_MS 1
`define CCVR_SS_MS 10
`define CCVR_HICCUP_MS 16
`define CCVR_PULSE_US 100
`define CCVR_FILT_CYC ((`CCVR_CLK_HZ / 1000) * `CCVR_FILT_MS)
`define CCVR_NEG_CYC ((`CCVR_CLK_HZ / 1000) * `CCVR_NEG_MS)
`define CCVR_DMLOW_CYC ((`CCVR_CLK_HZ / 1000) * `CCVR_DMLOW_MS)
`define CCVR_SS_CYC ((`CCVR_CLK_HZ / 1000) * `CCVR_SS_MS)
`define CCVR_HICCUP_CYC ((`CCVR_CLK_HZ / 1000) * `CCVR_HICCUP_MS)
`define CCVR_PULSE_CYC ((`CCVR_CLK_HZ / 1000000) * `CCVR_PULSE_US)
`endif

// File: ccvr_pkg.sv
// types of the charge port voltage request decoder
// assumes nothing beyond a SystemVerilog compiler
package ccvr_pkg;
  typedef enum logic [2:0] {
    pat_none, pat_5v2, pat_9v, pat_12v, pat_cont, pat_keep
  } ccvr_pat_t;
  typedef enum logic [4:0] {
    port_dcp = 5'b00001,
    port_negot = 5'b00010,
    port_wait_dm = 5'b00100,
    port_hv = 5'b01000,
    port_cont = 5'b10000
  } ccvr_port_t;
  typedef enum logic [3:0] {
    pwr_sstart = 4'b0001,
    pwr_run = 4'b0010,
    pwr_hiccup = 4'b0100,
    pwr_halt = 4'b1000
  } ccvr_pwr_t;
endpackage : ccvr_pkg

// File: ccvr_filt_if.sv
// carries a raw line pattern to the glitch filter and the filtered pattern back
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface ccvr_filt_if;
  ccvr_pkg::ccvr_pat_t raw;
  ccvr_pkg::ccvr_pat_t stable;
  logic strobe;
  modport filt (input raw, output stable, output strobe);
  modport user (output raw, input stable, input strobe);
endinterface : ccvr_filt_if

// File: ccvr_filter.sv
// glitch filter: commits a line pattern after it held unchanged for the filter count
// assumes raw comes from synchronised logic on clk_sys
`timescale 1ns/1ps
`include "ccvr_regs.svh"
module ccvr_filter #(
  parameter int FILT_CYC = `CCVR_FILT_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  ccvr_filt_if.filt fif
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYC - 1);
  if (FILT_CYC < 2) begin : g_chk
    $error("filter count too small");
  end
  ccvr_pkg::ccvr_pat_t cand_r, cand_nxt, stable_r, stable_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic strobe_r, strobe_nxt;
  always_comb begin
    cand_nxt = cand_r;
    cnt_nxt = cnt_r;
    stable_nxt = stable_r;
    strobe_nxt = 1'b0;
    if (fif.raw != cand_r) begin
      cand_nxt = fif.raw;
      cnt_nxt = '0;
    end else if (cnt_r != CNT_LAST) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (stable_r != cand_r) begin
      stable_nxt = cand_r; // RULE7
      strobe_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cand_r <= ccvr_pkg::pat_none;
      stable_r <= ccvr_pkg::pat_none;
      cnt_r <= '0;
      strobe_r <= 1'b0;
    end else begin
      cand_r <= cand_nxt;
      stable_r <= stable_nxt;
      cnt_r <= cnt_nxt;
      strobe_r <= strobe_nxt;
    end
  end
  assign fif.stable = stable_r;
  assign fif.strobe = strobe_r;
  a_filter_hold: assert property (@(posedge clk_sys) disable iff (srst) // RULE7
    strobe_r |-> ($past(cnt_r) == CNT_LAST && $past(cand_r) == stable_r))
    else $error("pattern committed before hold time");
  c_filter_commit: cover property (@(posedge clk_sys) disable iff (srst) strobe_r);
endmodule : ccvr_filter

// File: ccvr_pd_model.sv
// partner: the portable device on the data lines, turning line levels into comparator pins
// assumes level codes 0 ground, 1 source 0.6V, 2 high 3.3V, 3 released by the device
`timescale 1ns/1ps
module ccvr_pd_model (
  input wire logic clk_sys,
  input wire logic [1:0] dp_drv,
  input wire logic [1:0] dm_drv,
  input wire logic line_short_en,
  input wire logic dminus_pulldown_en,
  output logic dp_above_ref,
  output logic dp_above_sel,
  output logic dm_above_ref,
  output logic dm_above_sel
);
  logic flip = 1'b0;
  logic [1:0] dm_l;
  always @(posedge clk_sys) begin
    flip <= !flip;
  end
  // released D- follows the short, else the pull-down, else floats
  always_comb begin
    dm_l = dm_drv;
    if (dm_drv == 2'h3) begin
      dm_l = line_short_en ? dp_drv : (dminus_pulldown_en ? 2'h0 : {flip, 1'b0});
    end
  end
  always_comb begin
    dp_above_ref = dp_drv inside {2'h1, 2'h2};
    dp_above_sel = dp_drv == 2'h2;
    dm_above_ref = dm_l inside {2'h1, 2'h2};
    dm_above_sel = dm_l == 2'h2;
  end
endmodule : ccvr_pd_model

// File: ccvr_top_test.sv
// self-checking bench of the voltage request decoder
// assumes the small counts below; the device model drives the line comparators
`timescale 1ns/1ps
module ccvr_top_test;
  localparam int FC = 16;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] dp_drv = 2'h0;
  logic [1:0] dm_drv = 2'h3;
  logic dp_above_ref, dp_above_sel, dm_above_ref, dm_above_sel;
  logic sense_over = 1'b0, ilim_over = 1'b0, short_det = 1'b0, vout_over = 1'b0;
  logic temp_hot = 1'b0, temp_cool = 1'b1, vout_safe = 1'b1, pwm_cycle_start = 1'b0;
  logic [11:0] load_ma = 12'h000;
  logic line_short_en, dminus_pulldown_en, conv_en, soft_start, hs_allow, discharge_en;
  logic constant_current_mode, constant_voltage_mode;
  logic [7:0] vref_code, comp_mv;
  logic [7:0] ref_e = 8'h34;
  logic [31:0] q;
  int n_fail = 0;
  int samples_checked = 0;

  always #12.5 clk_sys = !clk_sys;

  ccvr_top #(.FILT_CYC(FC), .NEG_CYC(32), .DMLOW_CYC(8), .SS_CYC(8), .HICCUP_CYC(8),
    .PULSE_CYC(4)) DUT (.clk_sys, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .dp_above_ref, .dp_above_sel,
    .dm_above_ref, .dm_above_sel, .sense_over, .ilim_over, .short_det, .vout_over,
    .temp_hot, .temp_cool, .vout_safe, .load_ma, .pwm_cycle_start, .line_short_en,
    .dminus_pulldown_en, .vref_code, .comp_mv, .conv_en, .soft_start, .hs_allow,
    .discharge_en, .constant_current_mode, .constant_voltage_mode);

  ccvr_pd_model u_dev (.clk_sys, .dp_drv, .dm_drv, .line_short_en, .dminus_pulldown_en,
    .dp_above_ref, .dp_above_sel, .dm_above_ref, .dm_above_sel);

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic lines(input logic [1:0] p, input logic [1:0] m);
    @(posedge clk_sys);
    dp_drv <= p;
    dm_drv <= m;
  endtask : lines

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // pattern must not act before the filter time, then sets the reference
  task automatic pat(input logic [1:0] p, input logic [1:0] m, input logic [7:0] e);
    lines(p, m);
    cyc(FC - 2);
    chk(vref_code, ref_e);
    cyc(12);
    ref_e = e;
    chk(vref_code, ref_e);
  endtask : pat

  task automatic t_regs;
    chk({line_short_en, dminus_pulldown_en, vref_code}, {2'b10, 8'h34});
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    bus(1'b1, 4'h8, 32'h0000_0000);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(q[7:0], 8'h34);
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask : t_regs

  task automatic t_power;
    cyc(4);
    chk(hs_allow, 1'b1);
    load_ma <= 12'h1f4;
    cyc(3);
    chk(comp_mv, 8'h00);
    load_ma <= 12'h3e8;
    cyc(3);
    chk(comp_mv, 8'h3c);
    load_ma <= 12'hbb8;
    cyc(3);
    chk(comp_mv, 8'hb4);
    ilim_over <= 1'b1;
    cyc(4);
    ilim_over <= 1'b0;
    cyc(4);
    chk(hs_allow, 1'b0);
    pwm_cycle_start <= 1'b1;
    cyc(1);
    pwm_cycle_start <= 1'b0;
    cyc(3);
    chk(hs_allow, 1'b1);
    sense_over <= 1'b1;
    cyc(5);
    chk({constant_current_mode, constant_voltage_mode, hs_allow}, 3'b100);
    sense_over <= 1'b0;
    cyc(5);
    chk(constant_current_mode, 1'b0);
  endtask : t_power

  task automatic t_faults;
    short_det <= 1'b1;
    cyc(5);
    chk(conv_en, 1'b0);
    short_det <= 1'b0;
    cyc(22);
    chk({conv_en, soft_start}, 2'b10);
    vout_over <= 1'b1;
    cyc(5);
    chk(conv_en, 1'b0);
    vout_over <= 1'b0;
    cyc(5);
    chk(conv_en, 1'b1);
    temp_hot <= 1'b1;
    temp_cool <= 1'b0;
    cyc(5);
    temp_hot <= 1'b0;
    cyc(10);
    chk(conv_en, 1'b0);
    temp_cool <= 1'b1;
    cyc(5);
    chk({conv_en, soft_start}, 2'b11);
  endtask : t_faults

  task automatic t_legacy;
    // adjust off: a mid D+ must not start negotiation
    bus(1'b1, 4'h0, 32'hffff_fffe);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    lines(2'h1, 2'h3);
    cyc(50);
    chk({line_short_en, vref_code}, {1'b1, 8'h34});
    lines(2'h0, 2'h3);
    bus(1'b1, 4'h0, 32'h0000_0001);
    cyc(4);
    lines(2'h1, 2'h3);
    cyc(10);
    lines(2'h2, 2'h3);
    cyc(40);
    chk({line_short_en, vref_code}, {1'b1, 8'h34});
    // back to mid D+: the legacy mark keeps the port shorted
    lines(2'h1, 2'h3);
    cyc(50);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk({q[9], q[4:0], line_short_en}, {1'b1, 5'h01, 1'b1});
    lines(2'h0, 2'h3);
    cyc(10);
  endtask : t_legacy

  task automatic t_hv;
    lines(2'h1, 2'h3);
    cyc(40);
    chk({line_short_en, dminus_pulldown_en}, 2'b01);
    cyc(14);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(q[4:0], 5'h08);
    pat(2'h2, 2'h1, 8'h5a);
    pat(2'h1, 2'h1, 8'h78);
    pat(2'h1, 2'h2, 8'h78);
    pat(2'h1, 2'h3, 8'h34);
    pat(2'h2, 2'h2, 8'h34);
    cyc(8);
  endtask : t_hv

  task automatic t_cont;
    repeat (35) begin
      lines(2'h1, 2'h2);
      cyc(8);
      lines(2'h2, 2'h2);
      cyc(10);
      ref_e = (ref_e < 8'h78) ? ref_e + 8'h02 : ref_e;
      chk(vref_code, ref_e);
    end
    repeat (43) begin
      lines(2'h2, 2'h1);
      cyc(10);
      lines(2'h2, 2'h2);
      cyc(8);
      ref_e = (ref_e > 8'h24) ? ref_e - 8'h02 : ref_e;
      chk(vref_code, ref_e);
    end
  endtask : t_cont

  task automatic t_unplug;
    vout_safe <= 1'b0;
    lines(2'h0, 2'h3);
    cyc(FC + 10);
    chk({discharge_en, line_short_en, vref_code}, {2'b11, 8'h34});
    vout_safe <= 1'b1;
    cyc(5);
    chk(discharge_en, 1'b0);
  endtask : t_unplug

  initial begin
    cyc(5);
    srst <= 1'b0;
    cyc(12);
    t_regs;
    t_power;
    t_faults;
    t_legacy;
    t_hv;
    t_cont;
    t_unplug;
    stop_test;
  end

  initial begin
    cyc(20000);
    n_fail++;
    stop_test;
  end
endmodule : ccvr_top_test
